// [inc/gear_filter_pkg.sv]
package gear_filter_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [11:0] OFS_PPR       = 12'h000;
  localparam logic [11:0] OFS_R1_NUM    = 12'h004;
  localparam logic [11:0] OFS_R1_DEN    = 12'h008;
  localparam logic [11:0] OFS_R2_NUM    = 12'h00c;
  localparam logic [11:0] OFS_R2_DEN    = 12'h010;
  localparam logic [11:0] OFS_SWITCH    = 12'h014;
  localparam logic [11:0] OFS_LOWPASS   = 12'h018;
  localparam logic [11:0] OFS_MOVAVG    = 12'h01c;
  localparam logic [11:0] OFS_CLR_SEL   = 12'h020;
  localparam logic [11:0] OFS_ENC_BITS  = 12'h024;
  localparam logic [11:0] OFS_REF_SUM   = 12'h028;
  localparam logic [11:0] OFS_FB_SUM    = 12'h02c;
  localparam logic [11:0] OFS_DEV       = 12'h030;
  localparam logic [11:0] OFS_STATUS    = 12'h034;

  // ****************************************************************
  // Field widths and values after reset
  // ****************************************************************
  localparam int          POS_W         = 48;
  localparam int          PPR_W         = 21;
  localparam logic [20:0] RST_PPR       = 21'h000000;
  localparam logic [31:0] RST_RATIO     = 32'h00000001;
  localparam logic        RST_SWITCH    = 1'h0;
  localparam logic [3:0]  RST_SHIFT     = 4'h0;
  localparam logic [1:0]  RST_CLR_SEL   = 2'h0;
  localparam logic [4:0]  RST_ENC_BITS  = 5'h17;
  localparam logic [4:0]  MAX_ENC_BITS  = 5'h1f;

  // ****************************************************************
  // Deviation clear selections
  // ****************************************************************
  localparam logic [1:0]  CLR_NOT_RUN   = 2'h0;
  localparam logic [1:0]  CLR_FAULT     = 2'h1;
  localparam logic [1:0]  CLR_INPUT     = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_MHZ       = 40;
  localparam int          TICK_NS       = 1000;
  localparam int          TICK_CYCLES   = (TICK_NS * CLK_MHZ) / 1000;

  typedef enum logic [1:0] {
    SEL_R1,
    SEL_R2,
    SEL_PPR
  } gearSel_t;

endpackage

// [core/position_gear_filter_deviation.sv]
// Behaviour
// RL1 - Nonzero pulses-per-rev gives resolution over setting
// RL2 - Pair switching only when pulses-per-rev is zero
// RL3 - Exactly one gear ratio applied at once
// RL4 - Select input picks pair one or two
// RL5 - Ratio changes wait for switch condition
// RL6 - Encoder resolution is two to bit count
// RL7 - Low-pass and moving-average on scaled references
// RL8 - Filtering keeps total displacement unchanged
// RL9 - Deviation is reference sum minus feedback
// RL10 - Select 0 clears on disable or not running
// RL11 - Select 1 clears on disable or fault
// RL12 - Select 2 clears on disable or input
// RL13 - Software sets low-pass for sharp ratio changes
// RL14 - Reference scaled by numerator over denominator
// RL15 - Division remainder carried between samples
// RL16 - Clear loads feedback sum into reference sum
`timescale 1ns/100ps
module position_gear_filter_deviation #(
  parameter int REF_W       = 16,
  parameter int TICK_CYCLES = gear_filter_pkg::TICK_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     refValid,
  input  wire logic signed [REF_W-1:0]  refDelta,
  input  wire logic                     fbValid,
  input  wire logic signed [REF_W-1:0]  fbDelta,
  input  wire logic                     servoOn,
  input  wire logic                     driveRun,
  input  wire logic                     driveFault,
  input  wire logic                     gearSelIn,
  input  wire logic                     clearIn,
  output logic                          posRefValid,
  output logic signed [31:0]            posRefDelta,
  output logic signed [47:0]            deviation,
  output logic [1:0]                    gearActive,
  output logic                          clearActive
);

  localparam int PW = REF_W + 34;
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (REF_W < 2 || REF_W > 24) begin : g_chk_ref
    $error("REF_W must be 2 to 24");
  end
  if (TICK_CYCLES < 1 || TICK_CYCLES > 4096) begin : g_chk_tick
    $error("TICK_CYCLES must be 1 to 4096");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [4:0]                             syncA, syncB;
    logic [gear_filter_pkg::PPR_W-1:0]      ppr;
    logic [31:0]                            r1n, r1d, r2n, r2d;
    logic                                   swAny;
    logic [3:0]                             lpShift, maShift;
    logic [1:0]                             clrSel;
    logic [4:0]                             encBits;
    gear_filter_pkg::gearSel_t              actSel;
    logic [31:0]                            actNum, actDen;
    logic signed [32:0]                     rem;
    logic signed [47:0]                     pend1, pend2, inAcc;
    logic signed [47:0]                     refSum, fbSum, dev;
    logic [TW-1:0]                          tickCnt;
    logic                                   outValid;
    logic signed [31:0]                     outDelta;
    logic                                   clrFlag;
    logic [31:0]                            rdata;
  } state_t;

  state_t q, d;

  // Step toward zero; never stalls on a small nonzero residue
  function automatic logic signed [47:0] stepOf(
    input logic signed [47:0] p,
    input logic [3:0]         sh
  );
    logic signed [47:0] s;
    s = p >>> sh;
    if (s == 48'sh0 && p != 48'sh0) begin
      s = p[47] ? -48'sh1 : 48'sh1;
    end
    return s;
  endfunction

  logic                     servoS, runS, faultS, selS, clrInS;
  logic                     swOk, clearNow, tick, wrEn, rdEn, mapped;
  logic [31:0]              wantNum, wantDen;
  gear_filter_pkg::gearSel_t wantSel;
  logic signed [PW-1:0]     prod, quot, remW, denW;
  logic signed [47:0]       out1, out2, fbNext;
  assign {clrInS, selS, faultS, runS, servoS} = q.syncB;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign pready  = 1'b1;
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && !penable && !pwrite;
  assign mapped  = (paddr[1:0] == 2'h0) &&
                   (paddr <= gear_filter_pkg::OFS_STATUS);
  assign pslverr = psel && penable && !mapped;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.syncA = {clearIn, gearSelIn, driveFault, driveRun, servoOn};
    d.syncB = q.syncA;

    // Register writes
    if (wrEn && mapped) begin
      case (paddr)
        gear_filter_pkg::OFS_PPR:
          d.ppr = pwdata[gear_filter_pkg::PPR_W-1:0];
        gear_filter_pkg::OFS_R1_NUM:   d.r1n = pwdata;
        gear_filter_pkg::OFS_R1_DEN:   d.r1d = pwdata;
        gear_filter_pkg::OFS_R2_NUM:   d.r2n = pwdata;
        gear_filter_pkg::OFS_R2_DEN:   d.r2d = pwdata;
        gear_filter_pkg::OFS_SWITCH:   d.swAny = pwdata[0];
        gear_filter_pkg::OFS_LOWPASS:  d.lpShift = pwdata[3:0];
        gear_filter_pkg::OFS_MOVAVG:   d.maShift = pwdata[3:0];
        gear_filter_pkg::OFS_CLR_SEL:  d.clrSel = pwdata[1:0];
        gear_filter_pkg::OFS_ENC_BITS: begin
          // Resolution must fit the 32-bit numerator
          d.encBits = (pwdata[4:0] > gear_filter_pkg::MAX_ENC_BITS) ?
                      gear_filter_pkg::MAX_ENC_BITS : pwdata[4:0];
        end
        default: ;
      endcase
    end

    // Requested ratio
    if (q.ppr != '0) begin
      wantSel = gear_filter_pkg::SEL_PPR;                      // RL1
      wantNum = 32'h1 << q.encBits;                            // RL6
      wantDen = 32'(q.ppr);                                    // RL1
    end else if (selS) begin
      wantSel = gear_filter_pkg::SEL_R2;                       // RL2
      wantNum = q.r2n;                                         // RL4
      wantDen = q.r2d;
    end else begin
      wantSel = gear_filter_pkg::SEL_R1;                       // RL4
      wantNum = q.r1n;
      wantDen = q.r1d;
    end

    // Switch at once, or only while no reference is in flight
    swOk = q.swAny || (!refValid && q.pend1 == 48'sh0 &&
                       q.pend2 == 48'sh0);                     // RL5
    if (swOk) begin
      // One whole pair replaces the other in one edge
      d.actSel = wantSel;                                      // RL3
      d.actNum = wantNum;
      d.actDen = wantDen;
      if (wantNum != q.actNum || wantDen != q.actDen) begin
        d.rem = 33'sh0;
      end
    end

    // Gear scaling with carried remainder
    denW = PW'({1'b0, (q.actDen == 32'h0) ? 32'h1 : q.actDen});
    prod = PW'(refDelta) * PW'({1'b0, q.actNum}) + PW'(q.rem); // RL14
    quot = prod / denW;                                        // RL14
    remW = prod % denW;                                        // RL15
    if (refValid && !(swOk && (wantNum != q.actNum ||
                               wantDen != q.actDen))) begin
      d.rem = 33'(remW);                                       // RL15
    end

    // Filter tick divider
    tick = (q.tickCnt == TW'(TICK_CYCLES - 1));
    d.tickCnt = tick ? '0 : q.tickCnt + TW'(1);

    // Low-pass then moving-average on encoder units
    out1 = tick ? stepOf(q.pend1, q.lpShift) : 48'sh0;         // RL7
    out2 = tick ? stepOf(q.pend2, q.maShift) : 48'sh0;         // RL7
    d.pend1 = q.pend1 - out1;
    if (refValid) begin
      d.pend1 = d.pend1 + 48'(quot);
      d.inAcc = q.inAcc + 48'(quot);
    end
    d.pend2 = q.pend2 + out1 - out2;                           // RL8
    d.refSum = q.refSum + out2;                                // RL8
    d.outValid = tick && out2 != 48'sh0;
    d.outDelta = 32'(out2);

    fbNext = fbValid ? q.fbSum + 48'(fbDelta) : q.fbSum;
    d.fbSum = fbNext;

    // Deviation clear conditions
    case (q.clrSel)
      gear_filter_pkg::CLR_NOT_RUN: clearNow = !servoS || !runS;   // RL10
      gear_filter_pkg::CLR_FAULT:   clearNow = !servoS || faultS;  // RL11
      gear_filter_pkg::CLR_INPUT:   clearNow = !servoS || clrInS;  // RL12
      default:                      clearNow = !servoS;
    endcase
    d.clrFlag = clearNow;
    if (clearNow) begin
      // Pending filter counts are dropped so no stale motion follows
      d.refSum = fbNext;                                       // RL16
      d.inAcc = fbNext;
      d.pend1 = 48'sh0;
      d.pend2 = 48'sh0;
      d.rem = 33'sh0;
      d.outValid = 1'b0;
      d.outDelta = 32'sh0;
    end
    d.dev = d.refSum - d.fbSum;                                // RL9

    // Read data captured in the setup cycle
    if (rdEn) begin
      case (paddr)
        gear_filter_pkg::OFS_PPR:      d.rdata = 32'(q.ppr);
        gear_filter_pkg::OFS_R1_NUM:   d.rdata = q.r1n;
        gear_filter_pkg::OFS_R1_DEN:   d.rdata = q.r1d;
        gear_filter_pkg::OFS_R2_NUM:   d.rdata = q.r2n;
        gear_filter_pkg::OFS_R2_DEN:   d.rdata = q.r2d;
        gear_filter_pkg::OFS_SWITCH:   d.rdata = {31'h0, q.swAny};
        gear_filter_pkg::OFS_LOWPASS:  d.rdata = {28'h0, q.lpShift};
        gear_filter_pkg::OFS_MOVAVG:   d.rdata = {28'h0, q.maShift};
        gear_filter_pkg::OFS_CLR_SEL:  d.rdata = {30'h0, q.clrSel};
        gear_filter_pkg::OFS_ENC_BITS: d.rdata = {27'h0, q.encBits};
        gear_filter_pkg::OFS_REF_SUM:  d.rdata = q.refSum[31:0];
        gear_filter_pkg::OFS_FB_SUM:   d.rdata = q.fbSum[31:0];
        gear_filter_pkg::OFS_DEV:      d.rdata = q.dev[31:0];
        gear_filter_pkg::OFS_STATUS:
          d.rdata = {28'h0, q.clrFlag, swOk, 2'(q.actSel)};
        default:                       d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.ppr <= gear_filter_pkg::RST_PPR;
      q.r1n <= gear_filter_pkg::RST_RATIO;
      q.r1d <= gear_filter_pkg::RST_RATIO;
      q.r2n <= gear_filter_pkg::RST_RATIO;
      q.r2d <= gear_filter_pkg::RST_RATIO;
      q.swAny <= gear_filter_pkg::RST_SWITCH;
      q.lpShift <= gear_filter_pkg::RST_SHIFT;
      q.maShift <= gear_filter_pkg::RST_SHIFT;
      q.clrSel <= gear_filter_pkg::RST_CLR_SEL;
      q.encBits <= gear_filter_pkg::RST_ENC_BITS;
      q.actSel <= gear_filter_pkg::SEL_R1;
      q.actNum <= gear_filter_pkg::RST_RATIO;
      q.actDen <= gear_filter_pkg::RST_RATIO;
    end else begin
      q <= d;
    end
  end

  assign prdata      = q.rdata;
  assign posRefValid = q.outValid;
  assign posRefDelta = q.outDelta;
  assign deviation   = q.dev;
  assign gearActive  = 2'(q.actSel);
  assign clearActive = q.clrFlag;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ppr_ratio;
    (q.ppr != '0 && swOk) |=>
      (q.actSel == gear_filter_pkg::SEL_PPR &&
       q.actDen == 32'($past(q.ppr)));
  endproperty
  a_ppr_ratio: assert property (p_ppr_ratio) // RL1
    else $error("pulses-per-rev ratio not applied");
  property p_no_pair_switch;
    (q.ppr != '0 && swOk) |=> q.actSel != gear_filter_pkg::SEL_R2;
  endproperty
  a_no_pair_switch: assert property (p_no_pair_switch) // RL2
    else $error("pair two used with pulses-per-rev set");
  property p_one_ratio;
    swOk |=>
      (q.actNum == $past(q.r1n) && q.actDen == $past(q.r1d)) ||
      (q.actNum == $past(q.r2n) && q.actDen == $past(q.r2d)) ||
      (q.actNum == (32'h1 << $past(q.encBits)) &&
       q.actDen == 32'($past(q.ppr)));
  endproperty
  a_one_ratio: assert property (p_one_ratio) // RL3
    else $error("blended gear ratio");
  property p_pair_two;
    (q.ppr == '0 && swOk && selS) |=>
      (q.actSel == gear_filter_pkg::SEL_R2 && q.actNum == $past(q.r2n));
  endproperty
  a_pair_two: assert property (p_pair_two) // RL4
    else $error("pair two not selected");
  property p_switch_wait;
    !swOk |=> ($stable(q.actNum) && $stable(q.actDen));
  endproperty
  a_switch_wait: assert property (p_switch_wait) // RL5
    else $error("ratio changed outside switch condition");
  property p_resolution;
    (q.ppr != '0 && swOk) |=> q.actNum == (32'h1 << $past(q.encBits));
  endproperty
  a_resolution: assert property (p_resolution) // RL6
    else $error("encoder resolution wrong");
  property p_conserve;
    q.inAcc == q.refSum + q.pend1 + q.pend2;
  endproperty
  a_conserve: assert property (p_conserve) // RL8
    else $error("filter lost displacement");
  property p_dev_value;
    q.dev == q.refSum - q.fbSum;
  endproperty
  a_dev_value: assert property (p_dev_value) // RL9
    else $error("deviation not reference minus feedback");
  property p_clear_run;
    (q.clrSel == gear_filter_pkg::CLR_NOT_RUN && (!servoS || !runS))
      |=> (q.dev == 48'sh0 && q.clrFlag);
  endproperty
  a_clear_run: assert property (p_clear_run) // RL10
    else $error("deviation kept while not running");
  property p_clear_fault;
    (q.clrSel == gear_filter_pkg::CLR_FAULT && faultS)
      |=> q.dev == 48'sh0;
  endproperty
  a_clear_fault: assert property (p_clear_fault) // RL11
    else $error("deviation kept on fault");
  property p_clear_input;
    (q.clrSel == gear_filter_pkg::CLR_INPUT && $rose(clrInS))
      |=> q.dev == 48'sh0;
  endproperty
  a_clear_input: assert property (p_clear_input) // RL12
    else $error("deviation kept on clear input");
  property p_rem_bound;
    (q.rem < 0 ? -q.rem : q.rem) < 33'($signed({1'b0, q.actDen})) ||
    q.actDen == 32'h0;
  endproperty
  a_rem_bound: assert property (p_rem_bound) // RL15
    else $error("remainder exceeds denominator");
  property p_clear_load;
    clearNow |=> q.refSum == q.fbSum;
  endproperty
  a_clear_load: assert property (p_clear_load) // RL16
    else $error("clear did not load feedback sum");
  c_pair_two: cover property (q.actSel == gear_filter_pkg::SEL_R2 &&
                              posRefValid);
  c_ppr_mode: cover property (q.actSel == gear_filter_pkg::SEL_PPR &&
                              posRefValid);
  c_input_clear: cover property (q.clrSel == gear_filter_pkg::CLR_INPUT
                                 && $rose(clrInS));

endmodule

// [tb/ref_host.sv]
`timescale 1ns/100ps
module ref_host #(
  parameter int REF_W = 16
) (
  input  wire logic                    clk,
  output logic                         refValid,
  output logic signed [REF_W-1:0]      refDelta
);

  initial begin
    refValid = 1'b0;
    refDelta = '0;
  end

  // Gap 0 gives back-to-back samples, larger gaps a slow host
  // Idle data is inverted so a stale value never looks valid
  task automatic send(input int n, input logic signed [REF_W-1:0] d,
                      input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      refValid <= 1'b1;
      refDelta <= d;
      repeat (gap) begin
        @(posedge clk);
        refValid <= 1'b0;
        refDelta <= ~d;
      end
    end
    @(posedge clk);
    refValid <= 1'b0;
    refDelta <= ~d;
  endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
  // ****************************************
  // Signals
  // ****************************************
  logic                     clk;
  logic                     rst;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     refValid;
  logic signed [15:0]       refDelta;
  logic                     fbValid;
  logic signed [15:0]       fbDelta;
  logic                     servoOn;
  logic                     driveRun;
  logic                     driveFault;
  logic                     gearSelIn;
  logic                     clearIn;
  logic                     posRefValid;
  logic signed [31:0]       posRefDelta;
  logic signed [47:0]       deviation;
  logic [1:0]               gearActive;
  logic                     clearActive;
  logic signed [47:0]       outSum = '0;
  logic signed [47:0]       s0;
  int                       fails = 0;
  int                       nTests = 0;
  int                       cycles = 0;

  // Short tick keeps filter draining quick
  position_gear_filter_deviation #(.REF_W(16), .TICK_CYCLES(2)) i_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .refValid(refValid),
    .refDelta(refDelta), .fbValid(fbValid), .fbDelta(fbDelta),
    .servoOn(servoOn), .driveRun(driveRun), .driveFault(driveFault),
    .gearSelIn(gearSelIn), .clearIn(clearIn),
    .posRefValid(posRefValid), .posRefDelta(posRefDelta),
    .deviation(deviation), .gearActive(gearActive),
    .clearActive(clearActive));

  ref_host #(.REF_W(16)) i_host (
    .clk(clk), .refValid(refValid), .refDelta(refDelta));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (posRefValid === 1'b1) begin
      outSum <= outSum + 48'(posRefDelta);
    end
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrapUp();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    check("pready", 48'(pready), 48'h1);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdChk(input string what, input logic [11:0] a,
                       input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(what, 48'(rd), 48'(exp));
    check("pslverr", 48'(err), 48'(expErr));
  endtask

  // Pins are synchronised inside, so callers wait a few cycles
  task automatic pins(input logic on, run, flt, sel, clr);
    @(posedge clk);
    servoOn    <= on;
    driveRun   <= run;
    driveFault <= flt;
    gearSelIn  <= sel;
    clearIn    <= clr;
  endtask

  task automatic waitN(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic fbPulses(input int n, input logic signed [15:0] d);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      fbValid <= 1'b1;
      fbDelta <= d;
    end
    @(posedge clk);
    fbValid <= 1'b0;
    fbDelta <= ~d;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic testRegs();
    rdChk("ppr", gear_filter_pkg::OFS_PPR, 32'h0, 1'b0);
    rdChk("encBits", gear_filter_pkg::OFS_ENC_BITS, 32'h17, 1'b0);
    rdChk("clrSel", gear_filter_pkg::OFS_CLR_SEL, 32'h0, 1'b0);
    wr(12'h100, 32'h9);
    rdChk("unmapped", 12'h100, 32'h0, 1'b1);
    rdChk("r1num", gear_filter_pkg::OFS_R1_NUM, 32'h1, 1'b0);
    check("devRst", deviation, 48'h0);
    $display("test regs done");
  endtask

  task automatic testPair1();
    wr(gear_filter_pkg::OFS_SWITCH, 32'h1);
    wr(gear_filter_pkg::OFS_R1_NUM, 32'h3);
    wr(gear_filter_pkg::OFS_R1_DEN, 32'h2);
    pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    waitN(6);
    check("devStart", deviation, 48'h0);
    s0 = outSum;
    i_host.send(5, 16'sd1, 0);
    fbPulses(4, 16'sd2);
    waitN(60);
    check("gear1", 48'(gearActive), 48'(gear_filter_pkg::SEL_R1));
    check("sum1", outSum - s0, 48'sd7);
    check("dev1", deviation, -48'sd1);
    rdChk("fbReg", gear_filter_pkg::OFS_FB_SUM, 32'h8, 1'b0);
    rdChk("devReg", gear_filter_pkg::OFS_DEV, 32'hffffffff, 1'b0);
    $display("test pair one done");
  endtask

  task automatic testPair2();
    wr(gear_filter_pkg::OFS_R2_NUM, 32'h5);
    wr(gear_filter_pkg::OFS_R2_DEN, 32'h1);
    pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    waitN(6);
    check("gear2", 48'(gearActive), 48'(gear_filter_pkg::SEL_R2));
    s0 = outSum;
    i_host.send(2, -16'sd3, 3);
    waitN(60);
    check("sum2", outSum - s0, -48'sd30);
    check("dev2", deviation, -48'sd31);
    $display("test pair two done");
  endtask

  task automatic testPpr();
    wr(gear_filter_pkg::OFS_LOWPASS, 32'h2);
    wr(gear_filter_pkg::OFS_MOVAVG, 32'h1);
    wr(gear_filter_pkg::OFS_ENC_BITS, 32'h5);
    wr(gear_filter_pkg::OFS_PPR, 32'h8);
    waitN(6);
    check("gearP", 48'(gearActive), 48'(gear_filter_pkg::SEL_PPR));
    s0 = outSum;
    i_host.send(3, 16'sd3, 1);
    waitN(400);
    check("sumP", outSum - s0, 48'sd36);
    check("devP", deviation, 48'sd5);
    wr(gear_filter_pkg::OFS_PPR, 32'h0);
    waitN(6);
    check("gearBack", 48'(gearActive), 48'(gear_filter_pkg::SEL_R2));
    // Switch only when idle: pair stays while counts are in flight
    wr(gear_filter_pkg::OFS_SWITCH, 32'h0);
    s0 = outSum;
    i_host.send(1, 16'sd2, 0);
    pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    waitN(4);
    check("gearHeld", 48'(gearActive), 48'(gear_filter_pkg::SEL_R2));
    waitN(150);
    check("gearLate", 48'(gearActive), 48'(gear_filter_pkg::SEL_R1));
    check("sumHeld", outSum - s0, 48'sd10);
    $display("test pulses per rev done");
  endtask

  // Causes coded as {drive stopped, fault, clear input}
  task automatic testClear();
    logic [2:0] good [3];
    logic [2:0] bad  [3];
    good = '{3'b100, 3'b010, 3'b001};
    bad  = '{3'b001, 3'b100, 3'b010};
    for (int s = 0; s < 3; s++) begin
      wr(gear_filter_pkg::OFS_CLR_SEL, 32'(s));
      pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      waitN(5);
      check("devOff", deviation, 48'h0);
      pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      waitN(5);
      fbPulses(1, 16'sd4);
      pins(1'b1, !bad[s][2], bad[s][1], 1'b0, bad[s][0]);
      waitN(5);
      check("devKept", deviation, -48'sd4);
      check("clrIdle", 48'(clearActive), 48'h0);
      pins(1'b1, !good[s][2], good[s][1], 1'b0, good[s][0]);
      waitN(5);
      check("devClr", deviation, 48'h0);
      check("clrAct", 48'(clearActive), 48'h1);
    end
    // Select 3 clears on servo off only
    wr(gear_filter_pkg::OFS_CLR_SEL, 32'h3);
    pins(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    waitN(5);
    fbPulses(1, 16'sd4);
    waitN(5);
    check("devSel3", deviation, -48'sd4);
    check("clrSel3", 48'(clearActive), 48'h0);
    $display("test clear done");
  endtask

  task automatic wrapUp();
    $display("counts: %0d checks, %0d mismatches", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fbValid = 1'b0;
    fbDelta = 16'h0;
    servoOn = 1'b0;
    driveRun = 1'b0;
    driveFault = 1'b0;
    gearSelIn = 1'b0;
    clearIn = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    waitN(4);
    testRegs();
    testPair1();
    testPair2();
    testPpr();
    testClear();
    wrapUp();
  end
endmodule
